// >>> module_control_status_pins_tb_top.sv
// Testbench joining host end and module end through the pin interface.
// Assumes the software side speaks Avalon-MM with one wait cycle.
`timescale 1ns/100ps
`include "tlm_regs.svh"

module module_control_status_pins_tb_top;
  logic        ref_clk_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic [2:0]  av_addr     = 3'h0;
  logic        av_rd       = 1'b0;
  logic        av_wr       = 1'b0;
  logic [31:0] av_wdata    = 32'h0000_0000;
  logic [1:0]  strap       = 2'h1;
  logic [15:0] events      = 16'h0000;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        irq;
  logic        laser_on;
  logic        cooler_on;
  logic        cpu_reset;
  logic        proto_on;
  logic        software_laser_enable;
  logic [1:0]  strap_cap;
  logic [31:0] q;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  tlm_pins_if pins ();

  tlm_device_end #(.STRAP_W(2), .STAT_W(16)) tlm_device_end_i (
    .ref_clk_i               (ref_clk_i),
    .reset_i                 (reset_i),
    .pins                    (pins.dev),
    .strap_i                 (strap),
    .status_event_i          (events),
    .laser_on_o              (laser_on),
    .cooler_on_o             (cooler_on),
    .cpu_reset_o             (cpu_reset),
    .protocol_active_o       (proto_on),
    .strap_o                 (strap_cap),
    .software_laser_enable_o (software_laser_enable)
  );

  tlm_host_end tlm_host_end_i (
    .ref_clk_i         (ref_clk_i),
    .reset_i           (reset_i),
    .avs_address_i     (av_addr),
    .avs_read_i        (av_rd),
    .avs_write_i       (av_wr),
    .avs_writedata_i   (av_wdata),
    .avs_readdata_o    (av_rdata),
    .avs_waitrequest_o (av_wait),
    .irq_o             (irq),
    .pins              (pins.host)
  );

  tlm_pins_assertions tlm_pins_assertions_i (
    .ref_clk_i           (ref_clk_i),
    .reset_i             (reset_i),
    .hold_reset_low      (pins.hold_reset_low),
    .optical_kill_low    (pins.optical_kill_low),
    .link_ready_low      (pins.link_ready_low),
    .service_request_low (pins.service_request_low),
    .cmd_valid           (pins.cmd_valid),
    .cmd_write           (pins.cmd_write),
    .cmd_addr            (pins.cmd_addr),
    .cmd_wdata           (pins.cmd_wdata),
    .rsp_valid           (pins.rsp_valid),
    .rsp_rdata           (pins.rsp_rdata)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  task chk_bit(input logic got, input logic exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t bit %b, expected %b", $time, got, exp);
    end
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t word %h, expected %h", $time, got, exp);
    end
  endtask

  task wait_cy(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Request held until waitrequest is seen low at an edge
  task av(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    av_addr  <= a;
    av_wr    <= w;
    av_rd    <= !w;
    av_wdata <= d;
    do @(posedge ref_clk_i); while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task link(input logic w, input logic [7:0] a, input logic [15:0] d);
    av(1'b1, `TLM_HOST_CMD, {w, 7'h00, a, d});
    do av(1'b0, `TLM_HOST_RESULT, 32'h0000_0000); while (q[`TLM_RES_BUSY_BIT] !== 1'b0);
    q = q & 32'h0000_ffff;
  endtask

  // Pin writes cross two sync stages, so settle before looking
  task pin(input logic [1:0] v);
    av(1'b1, `TLM_HOST_PIN_CTRL, {30'h0000_0000, v});
    wait_cy(8);
  endtask

  task pulse(input logic [15:0] e);
    @(posedge ref_clk_i);
    events <= e;
    @(posedge ref_clk_i);
    events <= 16'h0000;
    wait_cy(6);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    wait_cy(1);
    chk_bit(laser_on | cooler_on | proto_on, 1'b0);
    chk_bit(cpu_reset, 1'b1);
    chk_bit(pins.link_ready_low, 1'b1);
    chk_bit(pins.service_request_low, 1'b1);
    av(1'b0, `TLM_HOST_PIN_CTRL, 32'h0000_0000);
    chk_word(q, 32'h0000_0002);
    av(1'b0, 3'h7, 32'h0000_0000);
    chk_word(q, 32'h0000_0000);
  endtask

  task t_hold_up;
    pin(2'h3);
    chk_bit(cpu_reset, 1'b0);
    chk_bit(proto_on, 1'b1);
    chk_bit(pins.link_ready_low, 1'b0);
    strap <= 2'h2;
    wait_cy(6);
    chk_word({30'h0000_0000, strap_cap}, 32'h0000_0001);
    link(1'b0, `TLM_ADDR_LASER_CTRL, 16'h0000);
    chk_word(q, 32'h0000_0100);
  endtask

  task t_kill;
    link(1'b1, `TLM_ADDR_SRQ_MASK, 16'h0004);
    link(1'b1, `TLM_ADDR_LASER_CTRL, 16'h0001);
    chk_bit(laser_on & software_laser_enable, 1'b1);
    pin(2'h1);
    chk_bit(laser_on | software_laser_enable, 1'b0);
    link(1'b0, `TLM_ADDR_SRQ_MASK, 16'h0000);
    chk_word(q, 32'h0000_0004);
    link(1'b1, `TLM_ADDR_LASER_CTRL, 16'h0001);
    chk_bit(laser_on, 1'b0);
    pin(2'h3);
    chk_bit(laser_on, 1'b0);
    link(1'b1, `TLM_ADDR_LASER_CTRL, 16'h0001);
    wait_cy(2);
    chk_bit(laser_on, 1'b1);
  endtask

  task t_srq;
    av(1'b1, `TLM_HOST_IRQ_MASK, 32'h0000_0002);
    pulse(16'h0002);
    chk_bit(pins.service_request_low, 1'b1);
    pulse(16'h0004);
    chk_bit(pins.service_request_low, 1'b0);
    chk_bit(irq, 1'b1);
    av(1'b0, `TLM_HOST_RESULT, 32'h0000_0000);
    chk_word(q & 32'h0007_0000, 32'h0006_0000);
    link(1'b0, `TLM_ADDR_STATUS, 16'h0000);
    chk_word(q, 32'h0000_0006);
    link(1'b1, `TLM_ADDR_SRQ_MASK, 16'h0000);
    link(1'b1, `TLM_ADDR_STATUS, 16'h0002);
    wait_cy(4);
    chk_bit(pins.service_request_low, 1'b0);
    link(1'b1, `TLM_ADDR_STATUS, 16'h0004);
    wait_cy(4);
    chk_bit(pins.service_request_low, 1'b1);
    av(1'b1, `TLM_HOST_IRQ_STATUS, 32'h0000_0003);
    wait_cy(2);
    chk_bit(irq, 1'b0);
    link(1'b0, 8'h55, 16'h0000);
    chk_word(q, 32'h0000_0000);
  endtask

  task t_hold_down;
    pin(2'h2);
    chk_bit(laser_on | cooler_on | proto_on, 1'b0);
    chk_bit(cpu_reset & pins.link_ready_low, 1'b1);
    pin(2'h3);
    link(1'b0, `TLM_ADDR_SRQ_MASK, 16'h0000);
    chk_word(q, 32'h0000_ffff);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_hold_up();
    t_kill();
    t_srq();
    t_hold_down();
    close_out();
  end
endmodule

// >>> tlm_device_end.sv
// Laser module end of the control pins: hold-in-reset, optical kill,
// link ready and latching service request, with the status and mask
// registers reached over the command link.
// Assumes the host drives the pins and command link of tlm_pins_if.
`timescale 1ns/100ps
`include "tlm_regs.svh"

module tlm_device_end #(
  parameter int STRAP_W = 2,
  parameter int STAT_W  = 16
) (
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  tlm_pins_if.dev                 pins,
  input  wire logic [STRAP_W-1:0] strap_i,
  input  wire logic [STAT_W-1:0]  status_event_i,
  output logic                    laser_on_o,
  output logic                    cooler_on_o,
  output logic                    cpu_reset_o,
  output logic                    protocol_active_o,
  output logic [STRAP_W-1:0]      strap_o,
  output logic                    software_laser_enable_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [STRAP_W+1:0] pins_sync;
  logic               hold_release;
  logic               kill_release;
  logic [STRAP_W-1:0] strap_sync;
  logic               hold_prev;
  logic               held;
  logic               killed;
  logic               hold_rise;

  // Resets to zero so the module starts held and killed
  tlm_sync2 #(
    .W    (STRAP_W + 2),
    .INIT ('0)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({strap_i, pins.optical_kill_low, pins.hold_reset_low}),
    .sync_o    (pins_sync)
  );

  assign hold_release = pins_sync[0];
  assign kill_release = pins_sync[1];
  assign strap_sync   = pins_sync[STRAP_W+1:2];
  assign held         = ~hold_release;
  assign killed       = ~kill_release;
  assign hold_rise    = hold_release & ~hold_prev;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hold_prev <= 1'b0;
    end else begin
      hold_prev <= hold_release;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Straps only change at a hold release, never mid-operation
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      strap_o <= '0;
    end else if (hold_rise) begin
      strap_o <= strap_sync;
    end
  end

  // ----------------------------------------
  // Command link decode
  // ----------------------------------------
  logic              take;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_ctrl;
  logic [STAT_W-1:0] module_status_flags;
  logic [STAT_W-1:0] service_trigger_mask;
  logic              request_pending;
  logic              status_clr_d;
  logic [STAT_W-1:0] srq_cause;
  logic              cause_left;

  // Commands are served even while a service request is pending
  assign take      = pins.cmd_valid & ~pins.link_ready_low & ~held;
  assign wr_status = take & pins.cmd_write & (pins.cmd_addr == `TLM_ADDR_STATUS);
  assign wr_mask   = take & pins.cmd_write & (pins.cmd_addr == `TLM_ADDR_SRQ_MASK);
  assign wr_ctrl   = take & pins.cmd_write & (pins.cmd_addr == `TLM_ADDR_LASER_CTRL);

  assign request_pending = |(module_status_flags & service_trigger_mask);
  assign cause_left      = |(srq_cause & module_status_flags);

  // Ready drops only when idle; busy from take until host drops valid
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      pins.link_ready_low <= 1'b1;
    end else if (take) begin
      pins.link_ready_low <= 1'b1;
    end else if (!pins.cmd_valid) begin
      pins.link_ready_low <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      pins.rsp_valid <= 1'b0;
    end else begin
      pins.rsp_valid <= take;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      pins.rsp_rdata <= 16'h0000;
    end else if (take) begin
      unique case (pins.cmd_addr)
        `TLM_ADDR_STATUS:     pins.rsp_rdata <= 16'(module_status_flags);
        `TLM_ADDR_SRQ_MASK:   pins.rsp_rdata <= 16'(service_trigger_mask);
        `TLM_ADDR_LASER_CTRL: begin
          pins.rsp_rdata <= 16'(({8'h00, 8'(strap_o)} << `TLM_CTRL_STRAP_LSB)
                                | (16'(software_laser_enable_o) << `TLM_CTRL_SOFTWARE_LASER_ENABLE_BIT));
        end
        default:              pins.rsp_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Status and trigger mask
  // ----------------------------------------
  // A new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      module_status_flags <= `TLM_STATUS_RESET;
    end else begin
      module_status_flags <= (module_status_flags
                              & ~(wr_status ? STAT_W'(pins.cmd_wdata) : '0))
                             | status_event_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      service_trigger_mask <= `TLM_MASK_RESET;
    end else if (wr_mask) begin
      service_trigger_mask <= STAT_W'(pins.cmd_wdata);
    end
  end

  // ----------------------------------------
  // Service request
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      status_clr_d <= 1'b0;
    end else begin
      status_clr_d <= wr_status;
    end
  end

  // Bits that raised the line stay owed until cleared, even if unmasked later
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      srq_cause <= '0;
    end else begin
      srq_cause <= (srq_cause & module_status_flags)
                   | (module_status_flags & service_trigger_mask);
    end
  end

  // Narrowing the mask alone does not release the line; a clear must
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      pins.service_request_low <= 1'b1;
    end else if (request_pending) begin
      pins.service_request_low <= 1'b0;
    end else if (status_clr_d && !cause_left) begin
      pins.service_request_low <= 1'b1;
    end
  end

  // ----------------------------------------
  // Laser control
  // ----------------------------------------
  // Kill wins over a same-cycle enable write
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || held) begin
      software_laser_enable_o <= 1'b0;
    end else if (killed) begin
      software_laser_enable_o <= 1'b0;
    end else if (wr_ctrl) begin
      software_laser_enable_o <= pins.cmd_wdata[`TLM_CTRL_SOFTWARE_LASER_ENABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      laser_on_o        <= 1'b0;
      cooler_on_o       <= 1'b0;
      cpu_reset_o       <= 1'b1;
      protocol_active_o <= 1'b0;
    end else begin
      laser_on_o        <= ~held & ~killed & software_laser_enable_o;
      cooler_on_o       <= ~held;
      cpu_reset_o       <= held;
      protocol_active_o <= ~held;
    end
  end

endmodule

// >>> tlm_host_end.sv
// Host board end: drives hold and kill pins, runs command link
// transfers and reports the service request, all under software
// control over an Avalon-MM slave with waitrequest.
// Assumes the module end of tlm_pins_if shares ref_clk_i.
`timescale 1ns/100ps
`include "tlm_regs.svh"

module tlm_host_end (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  tlm_pins_if.host         pins
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0]               pin_sync;
  logic                     ready_s;
  logic                     srq_s;
  logic                     srq_prev;
  tlm_pkg::tlm_host_state_t state;
  logic [15:0]              result;
  logic [1:0]               irq_status;
  logic [1:0]               irq_mask;
  logic                     bus_req;
  logic                     bus_go;
  logic                     cmd_wr;

  tlm_sync2 #(
    .W    (2),
    .INIT (2'h3)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({pins.service_request_low, pins.link_ready_low}),
    .sync_o    (pin_sync)
  );

  assign ready_s = ~pin_sync[0];
  assign srq_s   = ~pin_sync[1];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      srq_prev <= 1'b0;
    end else begin
      srq_prev <= srq_s;
    end
  end

  // ----------------------------------------
  // Avalon slave
  // ----------------------------------------
  // Fixed one wait state: answer at the second edge of a request
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_go  = bus_req & ~avs_waitrequest_o;
  assign cmd_wr  = bus_go & avs_write_i & (avs_address_i == `TLM_HOST_CMD);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      unique case (avs_address_i)
        `TLM_HOST_PIN_CTRL:   avs_readdata_o <= {30'h0000_0000,
                                                 pins.optical_kill_low, pins.hold_reset_low};
        `TLM_HOST_RESULT:     avs_readdata_o <= {13'h0000, ready_s, srq_s,
                                                 ~state[0], result};
        `TLM_HOST_IRQ_STATUS: avs_readdata_o <= {30'h0000_0000, irq_status};
        `TLM_HOST_IRQ_MASK:   avs_readdata_o <= {30'h0000_0000, irq_mask};
        default:              avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  // Hold stays high only while software keeps it so
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pins.hold_reset_low   <= 1'(`TLM_PIN_CTRL_RESET >> `TLM_PIN_HOLD_BIT);
      pins.optical_kill_low <= 1'(`TLM_PIN_CTRL_RESET >> `TLM_PIN_KILL_BIT);
    end else if (bus_go && avs_write_i && avs_address_i == `TLM_HOST_PIN_CTRL) begin
      pins.hold_reset_low   <= avs_writedata_i[`TLM_PIN_HOLD_BIT];
      pins.optical_kill_low <= avs_writedata_i[`TLM_PIN_KILL_BIT];
    end
  end

  // ----------------------------------------
  // Command link transfer
  // ----------------------------------------
  // A command written while busy is dropped
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state          <= tlm_pkg::tlm_h_idle;
      pins.cmd_valid <= 1'b0;
      pins.cmd_write <= 1'b0;
      pins.cmd_addr  <= 8'h00;
      pins.cmd_wdata <= 16'h0000;
      result         <= 16'h0000;
    end else begin
      unique case (state)
        tlm_pkg::tlm_h_idle: begin
          if (cmd_wr) begin
            pins.cmd_write <= avs_writedata_i[`TLM_CMD_WRITE_BIT];
            pins.cmd_addr  <= avs_writedata_i[`TLM_CMD_ADDR_LSB +: 8];
            pins.cmd_wdata <= avs_writedata_i[15:0];
            state          <= tlm_pkg::tlm_h_wait_rdy;
          end
        end
        tlm_pkg::tlm_h_wait_rdy: begin
          if (ready_s) begin
            pins.cmd_valid <= 1'b1;
            state          <= tlm_pkg::tlm_h_wait_rsp;
          end
        end
        tlm_pkg::tlm_h_wait_rsp: begin
          if (pins.rsp_valid) begin
            pins.cmd_valid <= 1'b0;
            result         <= pins.rsp_rdata;
            state          <= tlm_pkg::tlm_h_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [1:0] irq_set;

  assign irq_set = {srq_s & ~srq_prev,
                    pins.rsp_valid & (state == tlm_pkg::tlm_h_wait_rsp)};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_status <= `TLM_IRQ_RESET;
    end else if (bus_go && avs_write_i && avs_address_i == `TLM_HOST_IRQ_STATUS) begin
      irq_status <= (irq_status & ~avs_writedata_i[1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_mask <= `TLM_IRQ_RESET;
    end else if (bus_go && avs_write_i && avs_address_i == `TLM_HOST_IRQ_MASK) begin
      irq_mask <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule

// >>> tlm_pins_assertions.sv
// Checker of the pin and command link signals between both ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module tlm_pins_assertions (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        hold_reset_low,
  input wire logic        optical_kill_low,
  input wire logic        link_ready_low,
  input wire logic        service_request_low,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  logic take;
  logic clr;
  assign take = cmd_valid && !link_ready_low;
  assign clr  = take && cmd_write && (cmd_addr == 8'h21);

  // Synced hold sees high only after two samples
  sequence s_hold_up;
    hold_reset_low && $past(hold_reset_low) && $past(hold_reset_low, 2);
  endsequence
  sequence s_done;
    rsp_valid ##1 !cmd_valid;
  endsequence

  a_ready_in_hold: assert property (!hold_reset_low [*4] |-> link_ready_low)
    else $error("ready low while held in reset");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_busy_on_rsp: assert property (rsp_valid |-> link_ready_low)
    else $error("ready low during response");
  a_rsp_after_take: assert property (s_hold_up ##0 take |=> rsp_valid)
    else $error("taken command not answered");
  a_kill_keeps_link: assert property (s_hold_up ##0 (take && !optical_kill_low) |=> rsp_valid)
    else $error("command not answered under kill");
  a_srq_init_high: assert property ($fell(reset_i) |-> service_request_low)
    else $error("service request low after reset");
  a_srq_latches: assert property ($rose(service_request_low) |->
      $past(clr, 2) || $past(clr, 3) || !$past(hold_reset_low, 3) || !$past(hold_reset_low, 4))
    else $error("service request released without clear");
  a_ready_returns: assert property (s_done ##0 s_hold_up |-> ##[1:2] !link_ready_low)
    else $error("ready not restored after command");
  a_rdata_stands: assert property (s_hold_up ##0 !take |=> $stable(rsp_rdata))
    else $error("read data changed without command");
endmodule

// >>> tlm_pins_if.sv
// Pins between the laser module and the host board, plus the
// register command link that stands for the serial protocol.
// Assumes both ends share ref_clk_i in the bench.
`timescale 1ns/100ps

interface tlm_pins_if;
  logic        hold_reset_low;
  logic        optical_kill_low;
  logic        link_ready_low;
  logic        service_request_low;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;

  modport dev (
    input  hold_reset_low, optical_kill_low, cmd_valid, cmd_write, cmd_addr, cmd_wdata,
    output link_ready_low, service_request_low, rsp_valid, rsp_rdata
  );

  modport host (
    output hold_reset_low, optical_kill_low, cmd_valid, cmd_write, cmd_addr, cmd_wdata,
    input  link_ready_low, service_request_low, rsp_valid, rsp_rdata
  );
endinterface

// >>> tlm_pkg.sv
// Types used by the host end of the laser module control pins.
// Assumes nothing beyond a SystemVerilog compiler.
package tlm_pkg;

  typedef enum logic [2:0] {
    tlm_h_idle     = 3'b001,
    tlm_h_wait_rdy = 3'b010,
    tlm_h_wait_rsp = 3'b100
  } tlm_host_state_t;

endpackage

// >>> tlm_regs.svh
// Register offsets, field positions, reset values for the laser module
// control pins and for the host-side controller.
// Assumes inclusion by bare name from the files that need it.
`ifndef TLM_REGS_SVH
`define TLM_REGS_SVH

// ----------------------------------------
// Module registers over the command link
// ----------------------------------------
`define TLM_ADDR_STATUS       8'h21
`define TLM_ADDR_SRQ_MASK     8'h28
`define TLM_ADDR_LASER_CTRL   8'h31
`define TLM_CTRL_SOFTWARE_LASER_ENABLE_BIT     0
`define TLM_CTRL_STRAP_LSB    8
`define TLM_STATUS_RESET      16'h0000
`define TLM_MASK_RESET        16'hffff

// ----------------------------------------
// Host controller registers (word index)
// ----------------------------------------
`define TLM_HOST_PIN_CTRL     3'h0
`define TLM_HOST_CMD          3'h1
`define TLM_HOST_RESULT       3'h2
`define TLM_HOST_IRQ_STATUS   3'h3
`define TLM_HOST_IRQ_MASK     3'h4
`define TLM_PIN_HOLD_BIT      0
`define TLM_PIN_KILL_BIT      1
`define TLM_PIN_CTRL_RESET    2'h2
`define TLM_CMD_WRITE_BIT     31
`define TLM_CMD_ADDR_LSB      16
`define TLM_RES_BUSY_BIT      16
`define TLM_RES_SRQ_BIT       17
`define TLM_RES_READY_BIT     18
`define TLM_IRQ_DONE_BIT      0
`define TLM_IRQ_SRQ_BIT       1
`define TLM_IRQ_RESET         2'h0

`endif

// >>> tlm_sync2.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes the first stage is read by the second stage only.
`timescale 1ns/100ps

module tlm_sync2 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta   <= INIT;
      sync_o <= INIT;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
